/* File: rtl/sdsl_pkg.sv */
/*
 * Shared constants for the stall detect and stop block: register
 * offsets, field positions, reset values, widths, timing and states.
 * Assumes a 32-bit register port with byte addresses, one word each.
 */
package sdsl_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LOAD_W = 10;
    localparam int SGT_W  = 7;
    localparam int VEL_W  = 24;
    localparam int ZW_W   = 16;
    localparam int IRQ_W  = 3;
    localparam int CNT_W  = 8;

    // register offsets
    localparam logic [7:0] ADR_SWMODE  = 8'h00;
    localparam logic [7:0] ADR_SGT     = 8'h04;
    localparam logic [7:0] ADR_VLOW    = 8'h08;
    localparam logic [7:0] ADR_VHIGH   = 8'h0C;
    localparam logic [7:0] ADR_ZWAIT   = 8'h10;
    localparam logic [7:0] ADR_DRVSTAT = 8'h14;
    localparam logic [7:0] ADR_RAMPST  = 8'h18;
    localparam logic [7:0] ADR_VACT    = 8'h1C;
    localparam logic [7:0] ADR_IRQST   = 8'h20;
    localparam logic [7:0] ADR_IRQMSK  = 8'h24;

    // field positions
    localparam int SW_STOP_BIT   = 0;
    localparam int SW_FILT_BIT   = 1;
    localparam int DRV_LOAD_LSB  = 0;
    localparam int DRV_CNT_LSB   = 16;
    localparam int DRV_STALL_BIT = 24;
    localparam int RS_HALT_BIT   = 0;
    localparam int RS_WAIT_BIT   = 1;
    localparam int RS_VWIN_BIT   = 2;
    localparam int RS_EVENT_BIT  = 6;
    localparam int IRQ_STALL_BIT = 0;
    localparam int IRQ_MEAS_BIT  = 1;
    localparam int IRQ_RUN_BIT   = 2;

    // reset values
    localparam logic [1:0]        SWMODE_RST = 2'h0;
    localparam logic [SGT_W-1:0]  SGT_RST    = 7'h00;
    localparam logic [VEL_W-1:0]  VLOW_RST   = 24'h00_0000;
    localparam logic [VEL_W-1:0]  VHIGH_RST  = 24'h7F_FFFF;
    localparam logic [ZW_W-1:0]   ZWAIT_RST  = 16'h0000;
    localparam logic [IRQ_W-1:0]  IRQMSK_RST = 3'h0;
    localparam logic [LOAD_W-1:0] LOAD_RST   = 10'h3FF;

    // clocks per zero wait unit, and left shift that sets the weight of one offset step
    localparam int ZW_PRESCALE = 512;
    localparam int SGT_SCALE_SHIFT = 4;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALT,
        ST_WAIT
    } sdsl_state_e;

endpackage

/* File: rtl/sdsl_load_filter.sv */
/*
 * Applies the signed threshold offset to each raw load sample and
 * optionally averages four samples before reporting.
 * Assumes one raw sample strobe per full step, on the same clock.
 */
`timescale 1ns/10ps

module sdsl_load_filter
    import sdsl_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              sample_valid,
    input  wire logic [LOAD_W-1:0] raw_load,
    input  wire logic [SGT_W-1:0]  offset,
    input  wire logic              filter_en,
    output logic                   meas_valid,
    output logic      [LOAD_W-1:0] meas
);

    logic signed [11:0] off_ext;
    logic signed [11:0] sum;
    logic [LOAD_W-1:0]  adj;
    logic [11:0]        acc;
    logic [11:0]        next_acc;
    logic [1:0]         cnt;

    // a larger offset lifts the reading, so more load is needed for 0
    assign off_ext  = 12'(signed'(offset)) <<< SGT_SCALE_SHIFT;
    assign sum      = signed'({2'b00, raw_load}) + off_ext;
    assign adj      = sum[11] ? '0 :
                      (sum[10] ? '1 : sum[LOAD_W-1:0]);
    assign next_acc = acc + {2'b00, adj};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            acc        <= '0;
            cnt        <= '0;
            meas_valid <= 1'b0;
            meas       <= LOAD_RST;
        end else begin
            meas_valid <= 1'b0;
            if (!filter_en) begin
                acc <= '0;
                cnt <= '0;
                if (sample_valid) begin
                    meas       <= adj;
                    meas_valid <= 1'b1;
                end
            end else if (sample_valid) begin
                cnt <= cnt + 2'd1;
                if (cnt == 2'd3) begin
                    meas       <= next_acc[11:2];
                    meas_valid <= 1'b1;
                    acc        <= '0;
                end else begin
                    acc <= next_acc;
                end
            end
        end
    end

endmodule

/* File: rtl/sdsl_stall_stop.sv */
/*
 * Stall detection and stop-on-stall control for one motor axis, with
 * its register file, ramp halt control and interrupt.
 * Assumes the ramp generator, full step strobe and raw load samples
 * run on clk; software uses the plain register port.
 */
// Strobed register access and the register offsets were left to the implementer.
//
// Contract
// - load measurement refreshed every full step; with filter enabled the code refreshes it only every fourth full step
// - filter enable averages over four measurements
// - measurement of zero means stall
// - stall stop halts ramp, velocity forced zero
// - stall stop sets stall flag
// - status read clears event, restart after wait
// - resume when stop disabled or status read
// - lower and upper velocity thresholds gate detection
// - signed offset, positive lowers sensitivity
// - load measurement is ten bit unsigned
`timescale 1ns/10ps

module sdsl_stall_stop
    import sdsl_pkg::*;
#(
    parameter int ZW_DIV = ZW_PRESCALE
)
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              full_step,
    input  wire logic [LOAD_W-1:0] raw_load,
    input  wire logic [VEL_W-1:0]  ramp_velocity,
    output logic      [VEL_W-1:0]  actual_velocity,
    output logic                   ramp_halt,
    output logic                   irq
);

    localparam int DIV_W = $clog2(ZW_DIV + 1);

    // configuration
    logic                 stop_on_stall_enable;
    logic                 load_filter_enable;
    logic [SGT_W-1:0]     stall_threshold_offset;
    logic [VEL_W-1:0]     vel_low;
    logic [VEL_W-1:0]     vel_high;
    logic [ZW_W-1:0]      zero_wait_delay;
    logic [IRQ_W-1:0]     irq_mask;

    // status
    logic [LOAD_W-1:0]    load_measurement;
    logic                 stall_flag;
    logic                 stall_stop_event;
    logic [CNT_W-1:0]     stall_count;
    logic [IRQ_W-1:0]     irq_status;

    // control
    sdsl_state_e          state;
    sdsl_state_e          next_state;
    logic [ZW_W-1:0]      zw_cnt;
    logic [DIV_W-1:0]     div_cnt;
    logic                 zw_tick;

    logic                 meas_valid;
    logic [LOAD_W-1:0]    meas;

    sdsl_load_filter u_filter (
        .clk          (clk),
        .rst_b        (rst_b),
        .sample_valid (full_step),
        .raw_load     (raw_load),
        .offset       (stall_threshold_offset),
        .filter_en    (load_filter_enable),
        .meas_valid   (meas_valid),
        .meas         (meas)
    );

    // address decode
    wire sel_swmode  = (reg_addr == ADR_SWMODE);
    wire sel_sgt     = (reg_addr == ADR_SGT);
    wire sel_vlow    = (reg_addr == ADR_VLOW);
    wire sel_vhigh   = (reg_addr == ADR_VHIGH);
    wire sel_zwait   = (reg_addr == ADR_ZWAIT);
    wire sel_drvstat = (reg_addr == ADR_DRVSTAT);
    wire sel_rampst  = (reg_addr == ADR_RAMPST);
    wire sel_vact    = (reg_addr == ADR_VACT);
    wire sel_irqst   = (reg_addr == ADR_IRQST);
    wire sel_irqmsk  = (reg_addr == ADR_IRQMSK);

    wire wr_swmode   = reg_wr && sel_swmode;
    wire wr_sgt      = reg_wr && sel_sgt;
    wire wr_vlow     = reg_wr && sel_vlow;
    wire wr_vhigh    = reg_wr && sel_vhigh;
    wire wr_zwait    = reg_wr && sel_zwait;
    wire wr_irqst    = reg_wr && sel_irqst;
    wire wr_irqmsk   = reg_wr && sel_irqmsk;
    wire rd_rampst   = reg_rd && sel_rampst;

    // velocity magnitude against the operating window
    // the most negative value has no magnitude and reads as the largest
    wire [VEL_W-1:0] vel_abs = ramp_velocity[VEL_W-1] ?
                               VEL_W'(-ramp_velocity) : ramp_velocity;
    wire vel_in_window = (vel_abs >= vel_low) &&
                         (vel_abs <= vel_high);

    // a stall is a zero reading inside the velocity window
    wire stall_seen = meas_valid && (meas == '0) &&
                      vel_in_window;
    // only an armed, running axis reacts; disarmed zeros are ignored
    wire stop_hit = stall_seen && stop_on_stall_enable &&
                    (state == ST_RUN);

    // a zero delay lets the axis restart one cycle after the wait begins
    wire zw_done = (zw_cnt >= zero_wait_delay);

    // next-state logic of the halt sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (stop_hit) begin
                    next_state = ST_HALT;
                end
            end
            ST_HALT: begin
                if (!stop_on_stall_enable) begin
                    next_state = ST_RUN;
                end else if (rd_rampst) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!stop_on_stall_enable || zw_done) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // zero wait prescaler, one enable pulse per unit
    assign zw_tick = (div_cnt == DIV_W'(ZW_DIV - 1));

    always_ff @(posedge clk) begin
        if (!rst_b || state != ST_WAIT) begin
            div_cnt <= '0;
        end else if (zw_tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || state != ST_WAIT) begin
            zw_cnt <= '0;
        end else if (zw_tick && !zw_done) begin
            zw_cnt <= zw_cnt + 1'b1;
        end
    end

    // ramp outputs follow next_state so the stop takes effect at once
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            actual_velocity <= '0;
            ramp_halt       <= 1'b0;
        end else begin
            actual_velocity <= (next_state == ST_RUN) ?
                               ramp_velocity : '0;
            ramp_halt       <= (next_state != ST_RUN);
        end
    end

    // measurement register, ten bit unsigned
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            load_measurement <= LOAD_RST;
        end else if (meas_valid) begin
            load_measurement <= meas;
        end
    end

    // sticky flags: a new stall in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stall_flag       <= 1'b0;
            stall_stop_event <= 1'b0;
        end else begin
            if (stop_hit) begin
                stall_flag       <= 1'b1;
                stall_stop_event <= 1'b1;
            end else if (rd_rampst) begin
                stall_flag       <= 1'b0;
                stall_stop_event <= 1'b0;
            end
        end
    end

    // saturating count of stall stops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stall_count <= '0;
        end else if (stop_hit && stall_count != '1) begin
            stall_count <= stall_count + 1'b1;
        end
    end

    // configuration registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stop_on_stall_enable <= SWMODE_RST[SW_STOP_BIT];
            load_filter_enable   <= SWMODE_RST[SW_FILT_BIT];
        end else if (wr_swmode) begin
            stop_on_stall_enable <= reg_wdata[SW_STOP_BIT];
            load_filter_enable   <= reg_wdata[SW_FILT_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stall_threshold_offset <= SGT_RST;
        end else if (wr_sgt) begin
            stall_threshold_offset <= reg_wdata[SGT_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            vel_low  <= VLOW_RST;
            vel_high <= VHIGH_RST;
        end else begin
            if (wr_vlow) begin
                vel_low <= reg_wdata[VEL_W-1:0];
            end
            if (wr_vhigh) begin
                vel_high <= reg_wdata[VEL_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            zero_wait_delay <= ZWAIT_RST;
        end else if (wr_zwait) begin
            zero_wait_delay <= reg_wdata[ZW_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_mask <= IRQMSK_RST;
        end else if (wr_irqmsk) begin
            irq_mask <= reg_wdata[IRQ_W-1:0];
        end
    end

    // interrupt events: stall stop, new measurement, motion resumed
    wire resumed = (state != ST_RUN) && (next_state == ST_RUN);
    wire [IRQ_W-1:0] irq_set;
    assign irq_set[IRQ_STALL_BIT] = stop_hit;
    assign irq_set[IRQ_MEAS_BIT]  = meas_valid;
    assign irq_set[IRQ_RUN_BIT]   = resumed;

    // a mask write reaches irq one cycle late, the old mask still applies
    wire [IRQ_W-1:0] irq_clr = wr_irqst ? reg_wdata[IRQ_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_status <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            irq        <= |(((irq_status & ~irq_clr) | irq_set)
                            & irq_mask);
        end
    end

    // read data words
    logic [DATA_W-1:0] rd_swmode;
    logic [DATA_W-1:0] rd_drvstat;
    logic [DATA_W-1:0] rd_ramp;

    // fields land at their package positions; unused bits read 0
    always_comb begin
        rd_swmode                          = '0;
        rd_swmode[SW_STOP_BIT]             = stop_on_stall_enable;
        rd_swmode[SW_FILT_BIT]             = load_filter_enable;
        rd_drvstat                         = '0;
        rd_drvstat[DRV_LOAD_LSB +: LOAD_W] = load_measurement;
        rd_drvstat[DRV_CNT_LSB +: CNT_W]   = stall_count;
        rd_drvstat[DRV_STALL_BIT]          = stall_flag;
        rd_ramp                            = '0;
        rd_ramp[RS_HALT_BIT]               = (state != ST_RUN);
        rd_ramp[RS_WAIT_BIT]               = (state == ST_WAIT);
        rd_ramp[RS_VWIN_BIT]               = vel_in_window;
        rd_ramp[RS_EVENT_BIT]              = stall_stop_event;
    end

    wire [DATA_W-1:0] rd_mux =
        sel_swmode  ? rd_swmode :
        sel_sgt     ? {{(DATA_W-SGT_W){stall_threshold_offset[SGT_W-1]}},
                       stall_threshold_offset} :
        sel_vlow    ? {8'h00, vel_low} :
        sel_vhigh   ? {8'h00, vel_high} :
        sel_zwait   ? {16'h0000, zero_wait_delay} :
        sel_drvstat ? rd_drvstat :
        sel_rampst  ? rd_ramp :
        sel_vact    ? {{(DATA_W-VEL_W){actual_velocity[VEL_W-1]}},
                       actual_velocity} :
        sel_irqst   ? {29'h0000_0000, irq_status} :
        sel_irqmsk  ? {29'h0000_0000, irq_mask} :
                      32'h0000_0000;

    // read data stands only in the cycle after the strobe
    // clearing to 0 keeps a stale word off the bus between reads
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

/* File: testbench/sdsl_motor_model.sv */
/*
 * Motor side model: a full step pulse on request, with its raw load
 * sample, and the ramp velocity.
 * Assumes the block's clock; load lines toggle between steps.
 */
`timescale 1ns/10ps

module sdsl_motor_model
    import sdsl_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              step_req,
    input  wire logic [LOAD_W-1:0] load_val,
    input  wire logic [VEL_W-1:0]  vel_cmd,
    output logic                   full_step,
    output logic      [LOAD_W-1:0] raw_load,
    output logic      [VEL_W-1:0]  ramp_velocity
);
    always_ff @(posedge clk) begin
        full_step     <= rst_b & step_req;
        ramp_velocity <= vel_cmd;
        if (!rst_b) begin
            raw_load <= 10'h155;
        end else if (step_req) begin
            raw_load <= load_val;
        end else begin
            // not valid between steps, so toggled instead of held
            raw_load <= ~raw_load;
        end
    end
endmodule

/* File: testbench/sdsl_stall_stop_assertions.sv */
/*
 * Port checker for the stall stop block.
 * Assumes only the top ports are visible; bound below.
 */
`timescale 1ns/10ps

module sdsl_stall_stop_chk
    import sdsl_pkg::*;
#(
    parameter int ZW_DIV = ZW_PRESCALE
)
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire logic              full_step,
    input  wire logic [VEL_W-1:0]  ramp_velocity,
    input  wire logic [VEL_W-1:0]  actual_velocity,
    input  wire logic              ramp_halt,
    input  wire logic              irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic seen;

    // a halt may only end after software touched the bus
    always_ff @(posedge clk) begin
        if (!rst_b || !ramp_halt) begin
            seen <= 1'b0;
        end else if (reg_rd || reg_wr) begin
            seen <= 1'b1;
        end
    end

    halt_vel_zero_a: assert property (
        ramp_halt |-> actual_velocity == 24'h00_0000)
        else $error("velocity not zero while halted");
    run_vel_follow_a: assert property (
        $past(rst_b) && !ramp_halt && !$past(ramp_halt)
        |-> actual_velocity == $past(ramp_velocity))
        else $error("velocity does not follow ramp");
    stall_rise_a: assert property (
        $rose(ramp_halt) |-> $past(full_step, 2))
        else $error("halt without a measurement");
    halt_release_a: assert property (
        $past(rst_b) && $fell(ramp_halt) |-> seen)
        else $error("halt released without access");
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    stop_dis_run_a: assert property (
        reg_wr && reg_addr == ADR_SWMODE && !reg_wdata[SW_STOP_BIT]
        |-> ##[1:3] !ramp_halt)
        else $error("no resume after stop disabled");
    irq_fall_a: assert property (
        $past(rst_b) && $fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt dropped without a write");
    halt_bit_a: assert property (
        $past(reg_rd) && $past(reg_addr) == ADR_RAMPST
        |-> reg_rdata[RS_HALT_BIT] == $past(ramp_halt))
        else $error("halt bit disagrees with port");
endmodule

bind sdsl_stall_stop sdsl_stall_stop_chk #(.ZW_DIV(ZW_DIV)) i_chk (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .full_step(full_step),
    .ramp_velocity(ramp_velocity), .actual_velocity(actual_velocity),
    .ramp_halt(ramp_halt), .irq(irq));

/* File: testbench/tb_top.sv */
/*
 * Self-checking bench for the stall stop block and motor model.
 * Assumes the package, model and checker are compiled first.
 */
`timescale 1ns/10ps
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin \
    mismatches++; $display("BAD %0t %s", $time, m); end end

module tb_top
    import sdsl_pkg::*;
;
    logic              clk       = 1'b0;
    logic              rst_b     = 1'b0;
    logic [ADDR_W-1:0] reg_addr  = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic              rd_d      = 1'b0;
    logic              step_req  = 1'b0;
    logic [LOAD_W-1:0] load_val  = 10'h000;
    logic [VEL_W-1:0]  vel_cmd   = 24'h00_1000;
    logic [DATA_W-1:0] reg_rdata;
    logic              full_step;
    logic [LOAD_W-1:0] raw_load;
    logic [VEL_W-1:0]  ramp_velocity;
    logic [VEL_W-1:0]  actual_velocity;
    logic              ramp_halt;
    logic              irq;
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] msk_q[$];
    int                mismatches = 0;
    int                checked    = 0;
    int                cycles     = 0;

    always #20 clk = ~clk;

    // short wait units keep the zero wait delay cheap to simulate
    sdsl_stall_stop #(.ZW_DIV(4)) i_sdsl_stall_stop (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .full_step(full_step),
        .raw_load(raw_load), .ramp_velocity(ramp_velocity),
        .actual_velocity(actual_velocity), .ramp_halt(ramp_halt),
        .irq(irq));
    sdsl_motor_model i_sdsl_motor_model (
        .clk(clk), .rst_b(rst_b), .step_req(step_req),
        .load_val(load_val), .vel_cmd(vel_cmd), .full_step(full_step),
        .raw_load(raw_load), .ramp_velocity(ramp_velocity));

    task automatic summarize();
        if (mismatches == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic step(input logic [9:0] v);
        @(posedge clk);
        step_req <= 1'b1;
        load_val <= v;
        @(posedge clk);
        step_req <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (rd_d) begin
            `CHK(reg_rdata & msk_q[0], exp_q[0], "read data")
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        rd_d <= reg_rd;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end

    initial begin
        logic [9:0] a;
        int         s;
        void'($urandom(59));
        vel_cmd <= 24'h00_1000 + 24'($urandom_range(4095));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd(ADR_VHIGH, 32'h007F_FFFF, 32'h00FF_FFFF);
        rd(ADR_DRVSTAT, 32'h0000_03FF, 32'h0100_03FF);
        rd(ADR_SWMODE, 32'h0000_0000, 32'h0000_0003);
        rd(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
        a = 10'($urandom_range(900, 100));
        step(a);
        rd(ADR_DRVSTAT, {22'h00_0000, a}, 32'h0000_03FF);
        wr(ADR_SGT, 32'h0000_0002);
        step(a);
        rd(ADR_DRVSTAT, {22'h00_0000, a + 10'h020}, 32'h0000_03FF);
        step(10'h3F8);
        rd(ADR_DRVSTAT, 32'h0000_03FF, 32'h0000_03FF);
        wr(ADR_SGT, 32'h0000_007F);
        rd(ADR_SGT, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        step(10'h005);
        rd(ADR_DRVSTAT, 32'h0000_0000, 32'h0100_03FF);
        rd(ADR_RAMPST, 32'h0000_0000, 32'h0000_0041);
        wr(ADR_SGT, 32'h0000_0000);
        wr(ADR_SWMODE, 32'h0000_0002);
        s = 0;
        for (int i = 0; i < 4; i++) begin
            a = 10'($urandom_range(1023));
            s += a;
            step(a);
            if (i < 3) rd(ADR_DRVSTAT, 32'h0000_0000, 32'h0000_03FF);
        end
        rd(ADR_DRVSTAT, 32'(s >> 2), 32'h0000_03FF);
        wr(ADR_SWMODE, 32'h0000_0000);
        wr(ADR_IRQMSK, 32'h0000_0001);
        wr(ADR_ZWAIT, 32'h0000_0002);
        step(10'h200);
        wr(ADR_SWMODE, 32'h0000_0001);
        step(10'h000);
        `CHK(ramp_halt, 1'b1, "no halt")
        `CHK(actual_velocity, 24'h00_0000, "velocity kept")
        `CHK(irq, 1'b1, "no interrupt")
        repeat (20) @(posedge clk);
        rd(ADR_DRVSTAT, 32'h0101_0000, 32'h01FF_03FF);
        rd(ADR_IRQST, 32'h0000_0003, 32'h0000_0007);
        rd(ADR_RAMPST, 32'h0000_0041, 32'h0000_0043);
        rd(ADR_RAMPST, 32'h0000_0003, 32'h0000_0043);
        rd(ADR_DRVSTAT, 32'h0000_0000, 32'h0100_0000);
        for (int i = 0; i < 30 && ramp_halt; i++) @(posedge clk);
        @(negedge clk);
        `CHK(ramp_halt, 1'b0, "no restart")
        `CHK(actual_velocity, ramp_velocity, "velocity stuck")
        wr(ADR_IRQST, 32'h0000_0007);
        @(negedge clk);
        `CHK(irq, 1'b0, "interrupt stuck")
        step(10'h000);
        wr(ADR_SWMODE, 32'h0000_0000);
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK(ramp_halt, 1'b0, "no resume")
        rd(ADR_RAMPST, 32'h0000_0040, 32'h0000_0041);
        wr(ADR_VLOW, 32'h0000_4000);
        wr(ADR_SWMODE, 32'h0000_0001);
        step(10'h000);
        `CHK(ramp_halt, 1'b0, "halt below window")
        rd(ADR_RAMPST, 32'h0000_0000, 32'h0000_0005);
        wr(ADR_VLOW, 32'h0000_0000);
        wr(ADR_VHIGH, 32'h0000_0800);
        step(10'h000);
        `CHK(ramp_halt, 1'b0, "halt above window")
        wr(ADR_VHIGH, 32'h007F_FFFF);
        // reversed motion: the window works on the magnitude
        vel_cmd <= -vel_cmd;
        wr(ADR_IRQMSK, 32'h0000_0000);
        wr(ADR_IRQST, 32'h0000_0007);
        rd(ADR_VACT, {{8{vel_cmd[23]}}, vel_cmd}, 32'hFFFF_FFFF);
        step(10'h000);
        `CHK(ramp_halt, 1'b1, "no halt on reverse")
        `CHK(irq, 1'b0, "masked interrupt")
        rd(ADR_IRQST, 32'h0000_0001, 32'h0000_0001);
        summarize();
    end
endmodule
